// *** bench/ebac_mem_model.sv ***
`timescale 1ns/100ps
module ebac_mem_model (
	input  wire logic        mclk,  // Clock
	input  wire logic [7:0]  sel_n, // Chip selects
	input  wire logic [23:0] addr,  // Address pins
	input  wire logic        rd_n,  // Read strobe
	input  wire logic        hw_n,  // Upper write strobe
	input  wire logic        lw_n,  // Lower write strobe
	input  wire logic [15:0] dout,  // Data from block
	input  wire logic        is8,   // Wired as an 8-bit part
	output logic      [15:0] din    // Data to block
);
	logic [7:0]  mem [int];
	logic [15:0] junk = 16'h3c3c;
	logic        sel;
	function automatic logic [7:0] pat(input logic [23:0] a);
		return a[7:0] ^ 8'ha5;
	endfunction
	assign sel = sel_n != 8'hff;
	// Undriven lanes toggle so a stale value never passes
	assign din = !(sel && !rd_n) ? junk : is8 ? {pat(addr), ~junk[7:0]} :
		{pat({addr[23:1], 1'b0}), pat({addr[23:1], 1'b1})};
	always @(posedge mclk) begin
		junk <= ~junk;
		if (sel && !hw_n)
			mem[is8 ? int'(addr) : int'({addr[23:1], 1'b0})] = dout[15:8];
		if (sel && !lw_n)
			mem[int'({addr[23:1], 1'b1})] = dout[7:0];
	end
endmodule // ebac_mem_model

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
	import ebac_pkg::*;
	logic mclk = 0, arst_n = 0, mode_16m = 0, mode_8bit_rst = 0, cfg_we = 0;
	logic area0_brom = 0, brom_burst = 0, req = 0, req_write = 0, req_on_chip = 0;
	logic [7:0] area_width_select_reg = 0, area_state_count_reg = 0, area_dram = 0;
	logic [7:0] wait_count_high_reg = 0, wait_count_low_reg = 0;
	logic [3:1] cs_dir = 0;
	logic [7:4] chip_select_enable_reg = 0;
	ebac_size_t req_size = EBAC_SZ_BYTE;
	logic [23:0] req_addr = 0, addr_out;
	logic [31:0] req_wdata = 0, rdata;
	logic [15:0] data_in, data_out;
	logic busy, done, bus_16bit, rd_n, upper_write_strobe_n, lower_write_strobe_n;
	logic data_oe_hi, data_oe_lo, strb_q = 1, hw_s, lw_s, oe_s, is8 = 0;
	logic [7:0] area_select_n, area_select_oe, sel_s;
	int fail_count = 0, total_checks = 0, cyc = 0, lat, beats, l2, lat_rst;
	int lw [4];
	ebac_ctrl ebac_ctrl_inst (.mclk, .arst_n, .mode_16m, .mode_8bit_rst, .cfg_we,
		.area_width_select_reg, .area_state_count_reg, .wait_count_high_reg,
		.wait_count_low_reg, .area_dram, .area0_brom, .brom_burst, .cs_dir,
		.chip_select_enable_reg, .req, .req_write, .req_size, .req_addr, .req_on_chip,
		.req_wdata, .data_in, .busy, .done, .rdata, .bus_16bit, .addr_out, .area_select_n,
		.area_select_oe, .rd_n, .upper_write_strobe_n, .lower_write_strobe_n, .data_out,
		.data_oe_hi, .data_oe_lo);
	ebac_mem_model ebac_mem_model_inst (.mclk, .sel_n(area_select_n), .addr(addr_out),
		.rd_n, .hw_n(upper_write_strobe_n), .lw_n(lower_write_strobe_n), .dout(data_out),
		.is8, .din(data_in));
	initial forever #5 mclk = ~mclk;
	function automatic logic [7:0] pat(input logic [23:0] a);
		return a[7:0] ^ 8'ha5;
	endfunction
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// ==================================================
	// Monitor, sampled mid-cycle clear of the launching edge
	always @(negedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
		if (strb_q && !(rd_n && upper_write_strobe_n && lower_write_strobe_n))
			beats++;
		strb_q = rd_n && upper_write_strobe_n && lower_write_strobe_n;
		sel_s |= ~area_select_n;
		hw_s |= !upper_write_strobe_n;
		lw_s |= !lower_write_strobe_n;
		oe_s |= !rd_n && (data_oe_hi || data_oe_lo);
	end
	task automatic cfg(input logic [7:0] w, s, wl, wh);
		@(posedge mclk);
		#1;
		area_width_select_reg = w;
		area_state_count_reg = s;
		wait_count_low_reg = wl;
		wait_count_high_reg = wh;
		cfg_we = 1;
		@(posedge mclk);
		#1;
		cfg_we = 0;
		@(posedge mclk);
		#1;
	endtask
	task automatic xfer(input logic w, input ebac_size_t sz, input logic [23:0] a,
		input logic [31:0] d = 0, input logic oc = 0);
		@(posedge mclk);
		#1;
		{req, req_write, req_addr, req_wdata, req_on_chip} = {1'b1, w, a, d, oc};
		req_size = sz;
		{beats, sel_s, hw_s, lw_s, oe_s} = 0;
		@(posedge mclk);
		#1;
		req = 0;
		lat = 1;
		while (done !== 1'b1 && lat < 300) begin
			@(posedge mclk);
			#1;
			lat++;
		end
		chk(lat < 300, 1);
	endtask
	// ==================================================
	// Scenarios
	task automatic t_reset;
		chk(area_select_oe, 8'h01);
		xfer(0, EBAC_SZ_BYTE, 24'h020001);
		lat_rst = lat;
		chk(sel_s, 8'h02);
		@(posedge mclk);
		#1;
		cs_dir = 3'b101;
		chip_select_enable_reg = 4'b1010;
		repeat (2) @(posedge mclk);
		#1;
		chk(area_select_oe, 8'hab);
	endtask
	task automatic t_wait;
		for (int w = 0; w < 4; w++) begin
			cfg(8'h00, 8'hff, 8'(w << 2), 8'h00);
			xfer(0, EBAC_SZ_BYTE, 24'h020001);
			lw[w] = lat;
			chk(lw[w] - lw[0], w);
			chk(rdata[7:0], pat(24'h020001));
			chk(oe_s, 0);
		end
		chk(lat_rst - lw[0], 3);
		cfg(8'h00, 8'hfd, 8'hff, 8'hff);
		xfer(0, EBAC_SZ_BYTE, 24'h020001);
		l2 = lat;
		chk(lw[0] - l2, 1);
	endtask
	task automatic t_width;
		cfg(8'hff, 8'hff, 8'h00, 8'h00);
		chk(bus_16bit, 0);
		cfg(8'h01, 8'hff, 8'h00, 8'h00);
		chk(bus_16bit, 1);
		is8 = 1;
		xfer(0, EBAC_SZ_LONG, 24'h000010);
		chk(beats, 4);
		chk(rdata, {pat(24'h10), pat(24'h11), pat(24'h12), pat(24'h13)});
		xfer(1, EBAC_SZ_LONG, 24'h000020, 32'hdeadbeef);
		chk(beats, 4);
		chk(lw_s, 0);
		chk({ebac_mem_model_inst.mem[32], ebac_mem_model_inst.mem[33],
			ebac_mem_model_inst.mem[34], ebac_mem_model_inst.mem[35]}, 32'hdeadbeef);
		is8 = 0;
	endtask
	task automatic t_16;
		xfer(1, EBAC_SZ_LONG, 24'h020004, 32'h12345678);
		chk(beats, 2);
		chk({hw_s, lw_s}, 2'b11);
		chk({ebac_mem_model_inst.mem['h20004], ebac_mem_model_inst.mem['h20005],
			ebac_mem_model_inst.mem['h20006], ebac_mem_model_inst.mem['h20007]},
			32'h12345678);
		// Byte data travels in the top byte, first byte first
		xfer(1, EBAC_SZ_BYTE, 24'h020009, 32'hc3000000);
		chk({hw_s, lw_s}, 2'b01);
		chk(ebac_mem_model_inst.mem['h20009], 8'hc3);
		xfer(0, EBAC_SZ_LONG, 24'h020100);
		chk(rdata, {pat(24'h0), pat(24'h1), pat(24'h2), pat(24'h3)});
		chk({hw_s, lw_s}, 2'b00);
	endtask
	task automatic t_area;
		logic [32:0] tab [5] = '{{1'b0, 24'h01ffff, 8'h01}, {1'b0, 24'h020000, 8'h02},
			{1'b0, 24'h260000, 8'h08}, {1'b1, 24'h260000, 8'h02}, {1'b1, 24'he00000, 8'h80}};
		foreach (tab[i]) begin
			mode_16m = tab[i][32];
			xfer(0, EBAC_SZ_BYTE, tab[i][31:8]);
			chk(sel_s, tab[i][7:0]);
		end
		mode_16m = 0;
	endtask
	task automatic t_dram;
		area_dram = 8'h04;
		for (int i = 0; i < 2; i++) begin
			cfg(8'h01, i ? 8'hff : 8'hfb, 8'hff, 8'hff);
			xfer(0, EBAC_SZ_BYTE, 24'h040001);
			chk(lat - l2, 2);
		end
		area_dram = 0;
		area0_brom = 1;
		brom_burst = 1;
		cfg(8'h01, 8'hff, 8'h03, 8'h00);
		xfer(0, EBAC_SZ_BYTE, 24'h000001);
		chk(lat, lw[0]);
		{area0_brom, brom_burst} = 0;
	endtask
	task automatic t_onchip;
		cfg(8'hff, 8'hff, 8'hff, 8'hff);
		xfer(0, EBAC_SZ_LONG, 24'h020000, 0, 1);
		l2 = lat;
		chk(sel_s, 8'h00);
		cfg(8'h00, 8'h00, 8'h00, 8'h00);
		xfer(0, EBAC_SZ_LONG, 24'h020000, 0, 1);
		chk(lat, l2);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		#1;
		arst_n = 1;
		t_reset();
		t_wait();
		t_width();
		t_16();
		t_area();
		t_dram();
		t_onchip();
		end_sim();
	end
endmodule // tb

// *** design/ebac_ctrl.sv ***
`timescale 1ns/100ps
module ebac_ctrl (
	input  wire logic                mclk,          // System clock
	input  wire logic                arst_n,        // Async reset, active low
	input  wire logic                mode_16m,      // 16-Mbyte operating mode
	input  wire logic                mode_8bit_rst, // Reset width is 8-bit
	input  wire logic                cfg_we,        // Load area settings
	input  wire logic [7:0]          area_width_select_reg, // Width bits
	input  wire logic [7:0]          area_state_count_reg,  // State bits
	input  wire logic [7:0]          wait_count_high_reg,   // Wait fields 7..4
	input  wire logic [7:0]          wait_count_low_reg,    // Wait fields 3..0
	input  wire logic [7:0]          area_dram,     // Area is DRAM space, areas 2-5 only
	input  wire logic                area0_brom,    // Area 0 is burst ROM
	input  wire logic                brom_burst,    // Request is a burst beat
	input  wire logic [3:1]          cs_dir,        // Port direction, areas 1-3
	input  wire logic [7:4]          chip_select_enable_reg, // Enables, areas 4-7
	input  wire logic                req,           // Request valid
	input  wire logic                req_write,     // Request is a write
	input  wire ebac_pkg::ebac_size_t req_size,     // Request size
	input  wire logic [23:0]         req_addr,      // Request address
	input  wire logic                req_on_chip,   // Target is on-chip
	input  wire logic [31:0]         req_wdata,     // Write data
	input  wire logic [15:0]         data_in,       // Data pins in
	output logic                     busy,          // Request in progress
	output logic                     done,          // One-cycle completion
	output logic [31:0]              rdata,         // Read data
	output logic                     bus_16bit,     // 16-bit bus mode
	output logic [23:0]              addr_out,      // Address pins
	output logic [7:0]               area_select_n, // Chip select levels
	output logic [7:0]               area_select_oe,// Chip select drive enable
	output logic                     rd_n,          // Read strobe
	output logic                     upper_write_strobe_n, // Upper write strobe
	output logic                     lower_write_strobe_n, // Lower write strobe
	output logic [15:0]              data_out,      // Data pins out
	output logic                     data_oe_hi,    // Upper lane drive
	output logic                     data_oe_lo     // Lower lane drive
);
	import ebac_pkg::*;

	typedef enum logic [2:0] {
		EBAC_IDLE = 3'b000,
		EBAC_T1   = 3'b001,
		EBAC_T2   = 3'b010,
		EBAC_TW   = 3'b011,
		EBAC_T3   = 3'b100,
		EBAC_T4   = 3'b101
	} ebac_state_t;

	// ==================================================
	// Area configuration
	logic [7:0] three_st;
	logic [15:0] waits;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			three_st <= 8'hff;
			waits    <= 16'hffff;
		end else if (cfg_we) begin
			three_st <= area_state_count_reg;
			waits    <= {wait_count_high_reg, wait_count_low_reg};
		end
	end

	// Width strap caught after release, never in the reset branch
	logic strap_done;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			strap_done <= 1'b0;
		end else begin
			strap_done <= 1'b1;
		end
	end

	logic [7:0] width_eff;
	logic [7:0] strap_w;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			strap_w <= 8'h00;
		end else if (!strap_done) begin
			strap_w <= {8{mode_8bit_rst}};
		end else if (cfg_we) begin
			strap_w <= area_width_select_reg;
		end
	end
	assign width_eff = strap_done ? strap_w : {8{mode_8bit_rst}};

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bus_16bit <= 1'b1;
		end else begin
			bus_16bit <= ~&width_eff;
		end
	end

	// ==================================================
	// Request latch and decode
	logic [23:0] cur_addr;
	logic        cur_write;
	logic [1:0]  beats_left;
	logic [1:0]  beat_idx;
	logic        cur_word;
	logic        cur_chip;
	logic [31:0] wbuf;
	logic [2:0]  area;
	logic [7:0]  sel_n;
	logic        use_hi;
	logic        use_lo;
	logic        is8;

	ebac_decode u_decode (
		.addr     (cur_addr),
		.mode_16m (mode_16m),
		.on_chip  (cur_chip),
		.area     (area),
		.sel_n    (sel_n)
	);

	assign is8 = width_eff[area];

	ebac_lane u_lane (
		.is_8bit   (is8),
		.word_beat (cur_word),
		.odd       (cur_addr[0]),
		.use_hi    (use_hi),
		.use_lo    (use_lo)
	);

	// ==================================================
	// Access timing
	ebac_state_t state;
	logic [1:0]  wait_cnt;
	logic        area_dram_cur;
	logic        no_waits;
	logic [1:0]  wait_set;

	assign area_dram_cur = area_dram[area] && (area >= 3'd2) && (area <= 3'd5);
	assign wait_set = waits[{area, 1'b0} +: 2];
	// Burst ROM bursts and DRAM skip program waits
	assign no_waits = area_dram_cur || !three_st[area] ||
		(area0_brom && (area == 3'd0) && brom_burst);

	logic last_beat;
	assign last_beat = (beats_left == 2'd0);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state    <= EBAC_IDLE;
			wait_cnt <= 2'h0;
		end else begin
			case (state)
				EBAC_IDLE: begin
					if (req && !busy) begin
						state <= EBAC_T1;
					end
				end
				EBAC_T1: begin
					state <= EBAC_T2;
				end
				EBAC_T2: begin
					// On-chip cycles keep a fixed two states
					if (cur_chip || (!area_dram_cur && !three_st[area])) begin
						state <= last_beat ? EBAC_IDLE : EBAC_T1;
					end else if (!no_waits && wait_set != 2'h0) begin
						wait_cnt <= wait_set;
						state    <= EBAC_TW;
					end else begin
						state <= EBAC_T3;
					end
				end
				EBAC_TW: begin
					wait_cnt <= wait_cnt - 2'h1;
					if (wait_cnt == 2'h1) begin
						state <= EBAC_T3;
					end
				end
				EBAC_T3: begin
					if (area_dram_cur) begin
						state <= EBAC_T4;
					end else begin
						state <= last_beat ? EBAC_IDLE : EBAC_T1;
					end
				end
				EBAC_T4: begin
					state <= last_beat ? EBAC_IDLE : EBAC_T1;
				end
				default: begin
					state <= EBAC_IDLE;
				end
			endcase
		end
	end

	logic beat_end;
	assign beat_end = (state == EBAC_T4) ||
		(state == EBAC_T3 && !area_dram_cur) ||
		(state == EBAC_T2 && (cur_chip || (!area_dram_cur && !three_st[area])));

	// ==================================================
	// Beat splitting
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			busy       <= 1'b0;
			done       <= 1'b0;
			cur_addr   <= 24'h000000;
			cur_write  <= 1'b0;
			cur_word   <= 1'b0;
			cur_chip   <= 1'b0;
			beats_left <= 2'h0;
			beat_idx   <= 2'h0;
			wbuf       <= 32'h00000000;
		end else begin
			done <= 1'b0;
			if (state == EBAC_IDLE && req && !busy) begin
				busy      <= 1'b1;
				cur_addr  <= req_addr;
				cur_write <= req_write;
				cur_chip  <= req_on_chip;
				wbuf      <= req_wdata;
				beat_idx  <= 2'h0;
				// Longword in 8-bit area: four bytes; 16-bit area: two words; on-chip: one beat
				if (req_on_chip) begin
					cur_word   <= (req_size != EBAC_SZ_BYTE);
					beats_left <= 2'h0;
				end else if (width_eff[mode_16m ? req_addr[23:21] : req_addr[19:17]]) begin
					cur_word <= 1'b0;
					case (req_size)
						EBAC_SZ_WORD: beats_left <= 2'h1;
						EBAC_SZ_LONG: beats_left <= 2'h3;
						default:      beats_left <= 2'h0;
					endcase
				end else begin
					cur_word   <= (req_size != EBAC_SZ_BYTE);
					beats_left <= (req_size == EBAC_SZ_LONG) ? 2'h1 : 2'h0;
				end
			end else if (busy && beat_end) begin
				if (last_beat) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					beats_left <= beats_left - 2'h1;
					beat_idx   <= beat_idx + 2'h1;
					cur_addr   <= cur_addr + (cur_word ? 24'h000002 : 24'h000001);
				end
			end
		end
	end

	// ==================================================
	// Read capture
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 32'h00000000;
		end else if (busy && beat_end && !cur_write && !cur_chip) begin
			// Unused lane is ignored
			if (cur_word) begin
				rdata[(3'd1 - {2'b00, beat_idx[0]}) * 16 +: 16] <= data_in;
			end else if (use_hi) begin
				rdata[(5'd3 - {3'b000, beat_idx}) * 8 +: 8] <= data_in[15:8];
			end else begin
				rdata[7:0] <= data_in[7:0];
			end
		end
	end

	// ==================================================
	// Pin drive
	logic active;
	assign active = busy && (state != EBAC_IDLE) && !cur_chip;

	// Strobes rise for a state between beats, else a split access looks like one cycle
	logic strobe_on;
	assign strobe_on = active && !beat_end;

	logic [15:0] beat_data;
	assign beat_data = cur_word ? wbuf[(3'd1 - {2'b00, beat_idx[0]}) * 16 +: 16] :
		{2{wbuf[(5'd3 - {3'b000, beat_idx}) * 8 +: 8]}};

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			area_select_n <= 8'hff;
			addr_out      <= 24'h000000;
		end else begin
			area_select_n <= (busy && !cur_chip) ? sel_n : 8'hff;
			addr_out      <= cur_addr;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			area_select_oe <= {EBAC_CS_EN_RST, EBAC_CS_DIR_RST};
		end else begin
			area_select_oe <= {chip_select_enable_reg, cs_dir, 1'b1};
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_n                 <= 1'b1;
			upper_write_strobe_n <= 1'b1;
			lower_write_strobe_n <= 1'b1;
			data_out             <= 16'h0000;
			data_oe_hi           <= 1'b0;
			data_oe_lo           <= 1'b0;
		end else begin
			rd_n                 <= !(strobe_on && !cur_write);
			upper_write_strobe_n <= !(strobe_on && cur_write && use_hi);
			lower_write_strobe_n <= !(strobe_on && cur_write && use_lo && !is8);
			data_out             <= beat_data;
			data_oe_hi           <= active && cur_write;
			data_oe_lo           <= active && cur_write;
		end
	end

	// ==================================================
	// Checks
	sequence s_two_state;
		state == EBAC_T1 ##1 state == EBAC_T2;
	endsequence

	AST_ONCHIP_HIGH: assert property (@(posedge mclk) disable iff (!arst_n)
		busy && cur_chip |=> area_select_n == 8'hff)
		else $error("select low on on-chip access");
	AST_TWO_NO_WAIT: assert property (@(posedge mclk) disable iff (!arst_n)
		state == EBAC_T2 && !three_st[area] && !area_dram_cur |=> state != EBAC_TW)
		else $error("wait in two-state area");
	AST_DRAM_FOUR: assert property (@(posedge mclk) disable iff (!arst_n)
		state == EBAC_T3 && area_dram_cur |=> state == EBAC_T4)
		else $error("dram cycle short");
	AST_WAIT_PLACE: assert property (@(posedge mclk) disable iff (!arst_n)
		state == EBAC_TW |-> $past(state) == EBAC_T2 || $past(state) == EBAC_TW)
		else $error("wait not after second state");
	AST_WAIT_BOUND: assert property (@(posedge mclk) disable iff (!arst_n)
		s_two_state ##1 state == EBAC_TW |-> ##[1:3] state == EBAC_T3)
		else $error("wait run too long");
	AST_LWR_8BIT: assert property (@(posedge mclk) disable iff (!arst_n)
		active && is8 |=> lower_write_strobe_n)
		else $error("lower write strobe in 8-bit area");
	AST_CS0_OUT: assert property (@(posedge mclk) disable iff (!arst_n)
		##1 area_select_oe[0])
		else $error("area 0 select not driven");
	AST_RD_NO_WR: assert property (@(posedge mclk) disable iff (!arst_n)
		!rd_n |-> upper_write_strobe_n && lower_write_strobe_n)
		else $error("read and write strobes together");
	AST_BUSMODE: assert property (@(posedge mclk) disable iff (!arst_n)
		##1 bus_16bit == ~&$past(width_eff))
		else $error("bus mode mismatch");

endmodule // ebac_ctrl

// *** design/ebac_decode.sv ***
`timescale 1ns/100ps
module ebac_decode (
	input  wire logic [23:0] addr,       // Request address
	input  wire logic        mode_16m,   // 16-Mbyte mode
	input  wire logic        on_chip,    // On-chip target
	output logic      [2:0]  area,       // Selected area
	output logic      [7:0]  sel_n       // Decoded selects
);
	import ebac_pkg::*;

	// ==================================================
	// Area decode
	always_comb begin
		area = mode_16m ? addr[23:21] : addr[19:17];
		sel_n = 8'hff;
		if (!on_chip) begin
			sel_n[area] = 1'b0;
		end
	end

endmodule // ebac_decode

// *** design/ebac_lane.sv ***
`timescale 1ns/100ps
module ebac_lane (
	input  wire logic       is_8bit,   // Area width is 8 bits
	input  wire logic       word_beat, // Beat carries a word
	input  wire logic       odd,       // Beat address is odd
	output logic            use_hi,    // Upper lanes used
	output logic            use_lo     // Lower lanes used
);
	// ==================================================
	// Lane steering per beat
	always_comb begin
		if (is_8bit) begin
			use_hi = 1'b1;
			use_lo = 1'b0;
		end else if (word_beat) begin
			use_hi = 1'b1;
			use_lo = 1'b1;
		end else begin
			use_hi = !odd;
			use_lo = odd;
		end
	end

endmodule // ebac_lane

// *** include/ebac_pkg.sv ***
package ebac_pkg;
	// ==================================================
	// Access sizes and interface kinds
	typedef enum logic [1:0] {
		EBAC_SZ_BYTE = 2'b00,
		EBAC_SZ_WORD = 2'b01,
		EBAC_SZ_LONG = 2'b10
	} ebac_size_t;

	typedef enum logic [1:0] {
		EBAC_IF_BASIC = 2'b00,
		EBAC_IF_DRAM  = 2'b01,
		EBAC_IF_BROM  = 2'b10
	} ebac_iface_t;

	// ==================================================
	// Area geometry
	localparam int          EBAC_AREAS     = 8;
	localparam int          EBAC_ADDR_W    = 24;
	localparam int          EBAC_SEL_LO_1M = 17;
	localparam int          EBAC_SEL_LO_16M = 21;
	localparam logic [3:0]  EBAC_CS_DIR_RST = 4'h1;
	localparam logic [3:0]  EBAC_CS_EN_RST  = 4'h0;

	// ==================================================
	// State counts
	localparam logic [1:0]  EBAC_ST_TWO   = 2'h1;
	localparam logic [1:0]  EBAC_ST_THREE = 2'h2;
	localparam logic [1:0]  EBAC_ST_DRAM  = 2'h3;
endpackage
